/* File: design/pms_map.svh */
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// Register bus geometry
`define PMS_AW 4
`define PMS_DW 16

// Register offsets
`define PMS_REG_CTRL     4'h0
`define PMS_REG_STATUS   4'h1
`define PMS_REG_IRQ_STAT 4'h2
`define PMS_REG_IRQ_MASK 4'h3
`define PMS_REG_WAKE_EN  4'h4
`define PMS_REG_TMR_CMP  4'h5
`define PMS_REG_TMR_CNT  4'h6
`define PMS_REG_IO_EN    4'h7

// Control register fields
`define PMS_CTRL_MODE_LSB 0
`define PMS_CTRL_MODE_MSB 2
`define PMS_CTRL_LF_RC    3
`define PMS_CTRL_XTAL     4
`define PMS_CTRL_SLEEP    7

// Mode codes, lightest to deepest
`define PMS_MODE_ACTIVE  3'h0
`define PMS_MODE_IDLE    3'h1
`define PMS_MODE_LIGHT   3'h2
`define PMS_MODE_MIDDLE  3'h3
`define PMS_MODE_DEEPEST 3'h4
`define PMS_MODE_TRANS   3'h7

// Wake source bits: {timer, comparator, io pin, cpu interrupt}
`define PMS_WAKE_CPU 0
`define PMS_WAKE_IO  1
`define PMS_WAKE_CMP 2
`define PMS_WAKE_TMR 3
`define PMS_ALLOW_LIGHT   4'hF
`define PMS_ALLOW_MIDDLE  4'hE
`define PMS_ALLOW_DEEPEST 4'h6

// Interrupt status bits
`define PMS_EV_WAKE  0
`define PMS_EV_TMR   1
`define PMS_EV_IO    2
`define PMS_EV_RESET 3

// Reset values
`define PMS_CTRL_RST    16'h0000
`define PMS_MASK_RST    4'h0
`define PMS_WAKE_EN_RST 4'h7
`define PMS_CMP_RST     16'hFFFF
`define PMS_IO_EN_RST   9'h000

// Timing
`define PMS_CLK_NS         50
`define PMS_WAKE_LIGHT_NS  4000
`define PMS_WAKE_DEEP_NS   100000
`define PMS_WAKE_LIGHT_CYC ((`PMS_WAKE_LIGHT_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_WAKE_DEEP_CYC  ((`PMS_WAKE_DEEP_NS + `PMS_CLK_NS - 1) / `PMS_CLK_NS)
`define PMS_PD_STEP_CYC    4

`endif

/* File: design/pms_pkg.sv */
package pms_pkg;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_ACTIVE,
		ST_IDLE,
		ST_PD_CLK,
		ST_PD_RET,
		ST_LIGHT,
		ST_MIDDLE,
		ST_DEEPEST,
		ST_PU_REG,
		ST_PU_OSC,
		ST_RESET
	} state_t;

	// Power and clock controls driven to the analog domain
	typedef struct packed {
		logic regulator_on;
		logic rc_oscillator_en;
		logic crystal_oscillator_en;
		logic lf_crystal_en;
		logic lf_rc_en;
		logic cpu_halt;
		logic io_retain;
		logic reg_retain_full;
		logic periph_off;
	} pwr_ctrl_t;

	// Register bus request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} bus_req_t;

endpackage : pms_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// Three-stage pin synchroniser; the output moves once stages two and three agree
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] clean
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// Per-bit agreement filter
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
					clean[i] <= 1'b0;
				else if (s2_ff[i] == s3_ff[i])
					clean[i] <= s3_ff[i];
			end
		end
	endgenerate

	// Shift chain
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end
		else
		begin
			s1_ff <= pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end
endmodule : pin_sync

`default_nettype wire

/* File: design/sleep_timer.sv */
`timescale 1ns/1ns
`default_nettype none

// Free-running counter of low-frequency periods with a compare match pulse
module sleep_timer (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic [15:0] cmp,
	output logic      [15:0] count,
	output logic             match
);
	logic [15:0] nxt_count;

	assign nxt_count = count + 16'h0001;

	// Count only while the low-frequency oscillator runs
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			count <= 16'h0000;
			match <= 1'b0;
		end
		else
		begin
			match <= 1'b0;
			if (tick && run)
			begin
				count <= nxt_count;
				match <= (nxt_count == cmp);
			end
		end
	end
endmodule : sleep_timer

`default_nettype wire

/* File: design/power_mode_sequencer.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"

module power_mode_sequencer (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic [3:0]         reg_addr,
	input  wire logic [15:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [15:0]        reg_rdata,
	input  wire logic               cpu_irq_pend,
	input  wire logic [7:0]         io_pin,
	input  wire logic               comp_out,
	input  wire logic               lf_clk,
	input  wire logic               ext_rst_n,
	output pms_pkg::pwr_ctrl_t      pwr,
	output logic      [2:0]         cur_mode,
	output logic                    cpu_restart,
	output logic                    irq
);
	// Whole module state
	typedef struct packed {
		pms_pkg::state_t    st;
		logic [11:0]        cnt;
		logic [2:0]         target;
		logic [15:0]        ctrl;
		logic [3:0]         wake_en;
		logic [8:0]         io_en;
		logic [15:0]        cmp;
		logic [3:0]         irq_stat;
		logic [3:0]         irq_mask;
		logic [8:0]         pin_prev;
		logic               lf_prev;
		logic               by_reset;
		pms_pkg::pwr_ctrl_t pwr;
		logic [2:0]         mode;
		logic               restart;
		logic               irq;
		logic [15:0]        rdata;
	} seq_state_t;

	seq_state_t          q;
	seq_state_t          nxt_q;
	pms_pkg::bus_req_t   bus;
	logic [10:0]         pins_clean;
	logic [15:0]         tmr_count;
	logic                tmr_match;
	logic                lf_tick;
	logic                io_evt;
	logic [3:0]          evts;
	logic                ext_rst_act;

	assign bus.wr    = reg_wr;
	assign bus.rd    = reg_rd;
	assign bus.addr  = reg_addr;
	assign bus.wdata = reg_wdata;

	// External pins cross into the system clock; reset pin enters inverted so a cleared chain idles
	pin_sync #(
		.W (11)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin     ({~ext_rst_n, lf_clk, comp_out, io_pin}),
		.clean   (pins_clean)
	);

	// Low-frequency period edges and pin interrupt events
	assign lf_tick     = pins_clean[9] & ~q.lf_prev;
	assign io_evt      = |(pins_clean[8:0] & ~q.pin_prev & q.io_en);
	assign ext_rst_act = pins_clean[10];
	assign evts        = {tmr_match, io_evt & pins_clean[8], io_evt, cpu_irq_pend};

	// Sleep timer stops with the oscillator in deepest sleep
	sleep_timer u_tmr (
		.clk_sys (clk_sys),
		.rst     (rst),
		.tick    (lf_tick),
		.run     (q.pwr.lf_crystal_en | q.pwr.lf_rc_en),
		.cmp     (q.cmp),
		.count   (tmr_count),
		.match   (tmr_match)
	);

	// Mode reported for a state
	function automatic logic [2:0] mode_of(input pms_pkg::state_t s);
		case (s)
			pms_pkg::ST_ACTIVE:  mode_of = `PMS_MODE_ACTIVE;
			pms_pkg::ST_IDLE:    mode_of = `PMS_MODE_IDLE;
			pms_pkg::ST_LIGHT:   mode_of = `PMS_MODE_LIGHT;
			pms_pkg::ST_MIDDLE:  mode_of = `PMS_MODE_MIDDLE;
			pms_pkg::ST_DEEPEST: mode_of = `PMS_MODE_DEEPEST;
			default:             mode_of = `PMS_MODE_TRANS;
		endcase
	endfunction : mode_of

	// Wake decision: event, software enable and what the mode keeps alive
	function automatic logic wake_hit(
		input logic [3:0] ev,
		input logic [3:0] en,
		input logic [3:0] allow
	);
		wake_hit = |(ev & en & allow);
	endfunction : wake_hit

	// Next-state logic
	always_comb
	begin
		nxt_q          = q;
		nxt_q.restart  = 1'b0;
		nxt_q.rdata    = 16'h0000;
		nxt_q.lf_prev  = pins_clean[9];
		nxt_q.pin_prev = pins_clean[8:0];
		if (q.cnt != 12'h000)
			nxt_q.cnt = q.cnt - 12'h001;

		// Low-frequency source follows the control bit when awake
		if (!q.pwr.periph_off)
		begin
			nxt_q.pwr.lf_rc_en     = q.ctrl[`PMS_CTRL_LF_RC];
			nxt_q.pwr.lf_crystal_en = ~q.ctrl[`PMS_CTRL_LF_RC];
		end

		case (q.st)
			pms_pkg::ST_ACTIVE:
			begin
				nxt_q.pwr.crystal_oscillator_en = q.ctrl[`PMS_CTRL_XTAL];
				if (bus.wr && bus.addr == `PMS_REG_CTRL && bus.wdata[`PMS_CTRL_SLEEP])
				begin
					nxt_q.target = bus.wdata[`PMS_CTRL_MODE_MSB:`PMS_CTRL_MODE_LSB];
					case (bus.wdata[`PMS_CTRL_MODE_MSB:`PMS_CTRL_MODE_LSB])
						`PMS_MODE_IDLE:
						begin
							nxt_q.st           = pms_pkg::ST_IDLE;
							nxt_q.pwr.cpu_halt = 1'b1;
						end
						`PMS_MODE_LIGHT, `PMS_MODE_MIDDLE, `PMS_MODE_DEEPEST:
						begin
							nxt_q.st           = pms_pkg::ST_PD_CLK;
							nxt_q.pwr.cpu_halt = 1'b1;
							nxt_q.cnt          = 12'(`PMS_PD_STEP_CYC);
						end
						default:
							nxt_q.st = pms_pkg::ST_ACTIVE;
					endcase
				end
			end

			// Core halted, peripherals keep running
			pms_pkg::ST_IDLE:
			begin
				if (cpu_irq_pend)
				begin
					nxt_q.st           = pms_pkg::ST_ACTIVE;
					nxt_q.pwr.cpu_halt = 1'b0;
				end
			end

			// Power-down, first step: stop high-frequency clocks
			pms_pkg::ST_PD_CLK:
			begin
				if (q.cnt == 12'h000)
				begin
					nxt_q.pwr.rc_oscillator_en      = 1'b0;
					nxt_q.pwr.crystal_oscillator_en = 1'b0;
					if (q.target == `PMS_MODE_LIGHT)
						nxt_q.st = pms_pkg::ST_LIGHT;
					else
					begin
						nxt_q.st            = pms_pkg::ST_PD_RET;
						nxt_q.cnt           = 12'(`PMS_PD_STEP_CYC);
						nxt_q.pwr.io_retain = 1'b1;
					end
				end
			end

			// Power-down, second step: pins held, regulator and core domain off
			pms_pkg::ST_PD_RET:
			begin
				if (q.cnt == 12'h000)
				begin
					nxt_q.pwr.regulator_on = 1'b0;
					nxt_q.pwr.periph_off   = 1'b1;
					if (q.target == `PMS_MODE_DEEPEST)
					begin
						nxt_q.st                  = pms_pkg::ST_DEEPEST;
						nxt_q.pwr.lf_crystal_en   = 1'b0;
						nxt_q.pwr.lf_rc_en        = 1'b0;
						nxt_q.pwr.reg_retain_full = 1'b0;
					end
					else
						nxt_q.st = pms_pkg::ST_MIDDLE;
				end
			end

			// Light sleep: any enabled source, regulator still up
			pms_pkg::ST_LIGHT:
			begin
				if (wake_hit(evts, q.wake_en, `PMS_ALLOW_LIGHT))
				begin
					nxt_q.st                   = pms_pkg::ST_PU_OSC;
					nxt_q.pwr.rc_oscillator_en = 1'b1;
					nxt_q.cnt                  = 12'(`PMS_WAKE_LIGHT_CYC);
				end
			end

			// Middle sleep: pins, comparator and sleep timer wake
			pms_pkg::ST_MIDDLE:
			begin
				if (wake_hit(evts, q.wake_en, `PMS_ALLOW_MIDDLE))
				begin
					nxt_q.st               = pms_pkg::ST_PU_REG;
					nxt_q.pwr.regulator_on = 1'b1;
					nxt_q.cnt = 12'(`PMS_WAKE_DEEP_CYC - `PMS_WAKE_LIGHT_CYC);
				end
			end

			// Deepest sleep: only pin and comparator detection remain
			pms_pkg::ST_DEEPEST:
			begin
				if (wake_hit(evts, q.wake_en, `PMS_ALLOW_DEEPEST))
				begin
					nxt_q.st               = pms_pkg::ST_PU_REG;
					nxt_q.pwr.regulator_on = 1'b1;
					nxt_q.cnt = 12'(`PMS_WAKE_DEEP_CYC - `PMS_WAKE_LIGHT_CYC);
				end
			end

			// Regulator settles before the RC oscillator starts
			pms_pkg::ST_PU_REG:
			begin
				if (q.cnt == 12'h000)
				begin
					nxt_q.st                   = pms_pkg::ST_PU_OSC;
					nxt_q.pwr.rc_oscillator_en = 1'b1;
					nxt_q.pwr.periph_off       = 1'b0;
					nxt_q.cnt                  = 12'(`PMS_WAKE_LIGHT_CYC);
				end
			end

			// RC oscillator start-up, then the core clock is released
			pms_pkg::ST_PU_OSC:
			begin
				if (q.cnt == 12'h000)
				begin
					nxt_q.st                  = pms_pkg::ST_ACTIVE;
					nxt_q.pwr.cpu_halt        = 1'b0;
					nxt_q.pwr.io_retain       = 1'b0;
					nxt_q.pwr.reg_retain_full = 1'b1;
					nxt_q.restart             = q.by_reset;
					nxt_q.by_reset            = 1'b0;
				end
			end

			// Held by the reset pin; powers up fully on release
			pms_pkg::ST_RESET:
			begin
				if (!ext_rst_act)
				begin
					nxt_q.st  = pms_pkg::ST_PU_REG;
					nxt_q.cnt = 12'(`PMS_WAKE_DEEP_CYC - `PMS_WAKE_LIGHT_CYC);
				end
			end

			default:
				nxt_q.st = pms_pkg::ST_RESET;
		endcase

		// Reset pin overrides every mode
		if (ext_rst_act)
		begin
			nxt_q.st                   = pms_pkg::ST_RESET;
			nxt_q.by_reset             = 1'b1;
			nxt_q.pwr.regulator_on     = 1'b1;
			nxt_q.pwr.rc_oscillator_en = 1'b0;
			nxt_q.pwr.cpu_halt         = 1'b1;
		end

		// Register writes; the sleep bit is a strobe and is not stored
		if (bus.wr)
		begin
			case (bus.addr)
				`PMS_REG_CTRL:     nxt_q.ctrl     = bus.wdata & 16'h001F;
				`PMS_REG_IRQ_MASK: nxt_q.irq_mask = bus.wdata[3:0];
				`PMS_REG_WAKE_EN:  nxt_q.wake_en  = bus.wdata[3:0];
				`PMS_REG_TMR_CMP:  nxt_q.cmp      = bus.wdata;
				`PMS_REG_IO_EN:    nxt_q.io_en    = bus.wdata[8:0];
				`PMS_REG_IRQ_STAT: nxt_q.irq_stat = q.irq_stat & ~bus.wdata[3:0];
				default:           nxt_q.irq_stat = nxt_q.irq_stat;
			endcase
		end

		// Event capture wins over a clear in the same cycle
		if (q.st == pms_pkg::ST_PU_OSC && nxt_q.st == pms_pkg::ST_ACTIVE)
			nxt_q.irq_stat[`PMS_EV_WAKE] = 1'b1;
		if (tmr_match)
			nxt_q.irq_stat[`PMS_EV_TMR] = 1'b1;
		if (io_evt)
			nxt_q.irq_stat[`PMS_EV_IO] = 1'b1;
		if (ext_rst_act && q.st != pms_pkg::ST_RESET)
			nxt_q.irq_stat[`PMS_EV_RESET] = 1'b1;

		nxt_q.irq  = |(nxt_q.irq_stat & nxt_q.irq_mask);
		nxt_q.mode = mode_of(nxt_q.st);

		// Read data appear the cycle after the strobe only
		if (bus.rd)
		begin
			case (bus.addr)
				`PMS_REG_CTRL:     nxt_q.rdata = q.ctrl;
				`PMS_REG_STATUS:   nxt_q.rdata = {4'h0, q.pwr, mode_of(q.st)};
				`PMS_REG_IRQ_STAT: nxt_q.rdata = {12'h000, q.irq_stat};
				`PMS_REG_IRQ_MASK: nxt_q.rdata = {12'h000, q.irq_mask};
				`PMS_REG_WAKE_EN:  nxt_q.rdata = {12'h000, q.wake_en};
				`PMS_REG_TMR_CMP:  nxt_q.rdata = q.cmp;
				`PMS_REG_TMR_CNT:  nxt_q.rdata = tmr_count;
				`PMS_REG_IO_EN:    nxt_q.rdata = {7'h00, q.io_en};
				default:           nxt_q.rdata = 16'h0000;
			endcase
		end
	end

	// State register; reset lands in active with regulator and RC running
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			q                           <= '0;
			q.st                        <= pms_pkg::ST_ACTIVE;
			q.ctrl                      <= `PMS_CTRL_RST;
			q.wake_en                   <= `PMS_WAKE_EN_RST;
			q.irq_mask                  <= `PMS_MASK_RST;
			q.io_en                     <= `PMS_IO_EN_RST;
			q.cmp                       <= `PMS_CMP_RST;
			q.pwr.regulator_on          <= 1'b1;
			q.pwr.rc_oscillator_en      <= 1'b1;
			q.pwr.lf_crystal_en         <= 1'b1;
			q.pwr.reg_retain_full       <= 1'b1;
			q.mode                      <= `PMS_MODE_ACTIVE;
		end
		else
			q <= nxt_q;
	end

	// Outputs straight from the state register
	assign pwr         = q.pwr;
	assign cur_mode    = q.mode;
	assign cpu_restart = q.restart;
	assign irq         = q.irq;
	assign reg_rdata   = q.rdata;
endmodule : power_mode_sequencer

`default_nettype wire

/* File: sim/power_mode_sequencer_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"

// Port-level checks of mode, power controls and restart behaviour
module power_mode_sequencer_properties (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          reg_rd,
	input  wire logic [15:0]   reg_rdata,
	input  wire logic          cpu_irq_pend,
	input  wire pms_pkg::pwr_ctrl_t pwr,
	input  wire logic [2:0]    cur_mode,
	input  wire logic          cpu_restart
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_mode_legal: assert property (cur_mode inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7})
		else $error("mode code out of range");
	a_active_power: assert property (cur_mode == `PMS_MODE_ACTIVE |-> pwr.regulator_on
		&& (pwr.rc_oscillator_en || pwr.crystal_oscillator_en) && (pwr.lf_crystal_en || pwr.lf_rc_en))
		else $error("active mode power controls wrong");
	a_idle_halt: assert property (cur_mode == `PMS_MODE_IDLE |-> pwr.cpu_halt && !pwr.periph_off)
		else $error("idle mode must halt only the core");
	a_idle_resume: assert property (cur_mode == `PMS_MODE_IDLE && cpu_irq_pend |->
		##[1:2] cur_mode == `PMS_MODE_ACTIVE && !pwr.cpu_halt)
		else $error("idle did not resume on interrupt");
	a_light_power: assert property (cur_mode == `PMS_MODE_LIGHT |-> pwr.regulator_on &&
		!pwr.rc_oscillator_en && !pwr.crystal_oscillator_en && (pwr.lf_crystal_en || pwr.lf_rc_en))
		else $error("light sleep power controls wrong");
	a_middle_power: assert property (cur_mode == `PMS_MODE_MIDDLE |-> !pwr.regulator_on &&
		!pwr.rc_oscillator_en && !pwr.crystal_oscillator_en && pwr.periph_off
		&& (pwr.lf_crystal_en || pwr.lf_rc_en))
		else $error("middle sleep power controls wrong");
	a_deep_power: assert property (cur_mode == `PMS_MODE_DEEPEST |-> !pwr.regulator_on
		&& !pwr.rc_oscillator_en && !pwr.crystal_oscillator_en && !pwr.lf_crystal_en
		&& !pwr.lf_rc_en && !pwr.reg_retain_full)
		else $error("deepest sleep power controls wrong");
	a_pins_held: assert property (cur_mode inside {`PMS_MODE_MIDDLE, `PMS_MODE_DEEPEST}
		|-> pwr.io_retain && pwr.cpu_halt)
		else $error("pins not retained in deep sleep");
	a_wake_order: assert property ($rose(pwr.rc_oscillator_en) |->
		pwr.regulator_on && $past(pwr.regulator_on, 4))
		else $error("oscillator started before regulator");
	a_restart_pulse: assert property (cpu_restart |=> !cpu_restart
		&& cur_mode == `PMS_MODE_ACTIVE)
		else $error("restart pulse malformed");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data present without a read");
endmodule : power_mode_sequencer_properties

bind power_mode_sequencer power_mode_sequencer_properties i_props (
	.clk_sys     (clk_sys),
	.rst         (rst),
	.reg_rd      (reg_rd),
	.reg_rdata   (reg_rdata),
	.cpu_irq_pend(cpu_irq_pend),
	.pwr         (pwr),
	.cur_mode    (cur_mode),
	.cpu_restart (cpu_restart)
);
`default_nettype wire

/* File: sim/power_mode_sequencer_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pms_map.svh"

module power_mode_sequencer_bench;
	logic               clk_sys = 1'b0;
	logic               rst = 1'b1;
	logic [3:0]         reg_addr = 4'h0;
	logic [15:0]        reg_wdata = 16'h0000;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [15:0]        reg_rdata;
	logic               cpu_irq_pend = 1'b0;
	logic [7:0]         io_pin = 8'h00;
	logic               comp_out = 1'b0;
	logic               ext_rst_n = 1'b1;
	logic [3:0]         lf_div = 4'h0;
	pms_pkg::pwr_ctrl_t pwr;
	logic [2:0]         cur_mode;
	logic               cpu_restart;
	logic               irq;
	int                 bad_count = 0;
	int                 total_checks = 0;
	int                 n;

	power_mode_sequencer i_power_mode_sequencer (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cpu_irq_pend(cpu_irq_pend), .io_pin(io_pin),
		.comp_out(comp_out), .lf_clk(lf_div[3]), .ext_rst_n(ext_rst_n), .pwr(pwr),
		.cur_mode(cur_mode), .cpu_restart(cpu_restart), .irq(irq));

	// 50 ns system clock and a fast stand-in for the low-frequency clock
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) lf_div <= lf_div + 4'h1;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdval(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rdval

	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rdval(a, d);
		chk(d, exp);
	endtask : rdchk

	// Waits a bounded number of cycles for a mode, then checks it and the power word
	task automatic wait_mode(input logic [2:0] m, input int lim, input logic [8:0] pw);
		#1 n = 0;
		while (cur_mode !== m && n < lim)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk({13'h0000, cur_mode}, {13'h0000, m});
		chk({7'h00, pwr}, {7'h00, pw});
	endtask : wait_mode

	task automatic t_regs();
		logic [3:0]  ra [8] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
		logic [15:0] rv [8] = '{16'h0000, 16'h0D10, 16'h0000, 16'h0007, 16'hFFFF,
			16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 8; i++)
		begin
			if (i != 5)
				rdchk(ra[i], rv[i]);
		end
		wr(`PMS_REG_STATUS, 16'hFFFF);
		rdchk(`PMS_REG_STATUS, 16'h0D10);
		wr(`PMS_REG_IRQ_MASK, 16'hFFFF);
		rdchk(`PMS_REG_IRQ_MASK, 16'h000F);
		wr(`PMS_REG_IRQ_MASK, 16'h0000);
		wr(`PMS_REG_CTRL, 16'h0018);
		rdchk(`PMS_REG_STATUS, 16'h0E90);
		wr(`PMS_REG_CTRL, 16'h0003);
		repeat (8) @(posedge clk_sys);
		#1 chk({13'h0000, cur_mode}, 16'h0000);
		rdchk(`PMS_REG_CTRL, 16'h0003);
		wr(`PMS_REG_CTRL, 16'h0080);
		rdchk(`PMS_REG_STATUS, 16'h0D10);
		$display("test registers done");
	endtask : t_regs

	task automatic t_idle_light();
		wr(`PMS_REG_CTRL, 16'h0081);
		wait_mode(`PMS_MODE_IDLE, 4, 9'h1AA);
		@(posedge clk_sys);
		cpu_irq_pend <= 1'b1;
		wait_mode(`PMS_MODE_ACTIVE, 4, 9'h1A2);
		@(posedge clk_sys);
		cpu_irq_pend <= 1'b0;
		wr(`PMS_REG_CTRL, 16'h0082);
		wait_mode(`PMS_MODE_LIGHT, 30, 9'h12A);
		@(posedge clk_sys);
		cpu_irq_pend <= 1'b1;
		wait_mode(`PMS_MODE_ACTIVE, 200, 9'h1A2);
		chk(16'(n >= 78 && n <= 86), 16'h0001);
		@(posedge clk_sys);
		cpu_irq_pend <= 1'b0;
		$display("test idle and light done");
	endtask : t_idle_light

	task automatic t_middle();
		wr(`PMS_REG_IO_EN, 16'h0001);
		wr(`PMS_REG_IRQ_MASK, 16'h0001);
		wr(`PMS_REG_CTRL, 16'h0083);
		wait_mode(`PMS_MODE_MIDDLE, 40, 9'h02F);
		@(posedge clk_sys);
		io_pin <= 8'h01;
		wait_mode(`PMS_MODE_ACTIVE, 2100, 9'h1A2);
		chk(16'(n >= 1995 && n <= 2012), 16'h0001);
		rdchk(`PMS_REG_IRQ_STAT, 16'h0005);
		chk({15'h0000, irq}, 16'h0001);
		wr(`PMS_REG_IRQ_MASK, 16'h0000);
		repeat (2) @(posedge clk_sys);
		#1 chk({15'h0000, irq}, 16'h0000);
		wr(`PMS_REG_IRQ_MASK, 16'h0001);
		repeat (2) @(posedge clk_sys);
		#1 chk({15'h0000, irq}, 16'h0001);
		wr(`PMS_REG_IRQ_STAT, 16'h000F);
		repeat (2) @(posedge clk_sys);
		#1 chk({15'h0000, irq}, 16'h0000);
		rdchk(`PMS_REG_IRQ_STAT, 16'h0000);
		$display("test middle sleep done");
	endtask : t_middle

	task automatic t_deep();
		logic [15:0] c0;
		logic [15:0] c1;
		wr(`PMS_REG_IO_EN, 16'h0100);
		wr(`PMS_REG_CTRL, 16'h0084);
		wait_mode(`PMS_MODE_DEEPEST, 40, 9'h00D);
		rdval(`PMS_REG_TMR_CNT, c0);
		@(posedge clk_sys);
		cpu_irq_pend <= 1'b1;
		repeat (20) @(posedge clk_sys);
		#1 chk({13'h0000, cur_mode}, 16'h0004);
		rdval(`PMS_REG_TMR_CNT, c1);
		chk(c1 - c0, 16'h0000);
		@(posedge clk_sys);
		cpu_irq_pend <= 1'b0;
		comp_out <= 1'b1;
		wait_mode(`PMS_MODE_ACTIVE, 2100, 9'h1A2);
		chk(16'(n >= 1995 && n <= 2012), 16'h0001);
		@(posedge clk_sys);
		comp_out <= 1'b0;
		rdchk(`PMS_REG_IRQ_STAT, 16'h0005);
		wr(`PMS_REG_IRQ_STAT, 16'h000F);
		$display("test deepest sleep done");
	endtask : t_deep

	// Counts ticks of the 16-cycle stand-in clock, then a compare match a few ticks ahead
	task automatic t_timer();
		logic [15:0] c0;
		logic [15:0] c1;
		wr(`PMS_REG_TMR_CMP, 16'h0000);
		wr(`PMS_REG_IRQ_STAT, 16'h000F);
		repeat (100) @(posedge clk_sys);
		rdchk(`PMS_REG_IRQ_STAT, 16'h0000);
		rdval(`PMS_REG_TMR_CNT, c0);
		repeat (158) @(posedge clk_sys);
		rdval(`PMS_REG_TMR_CNT, c1);
		chk(c1 - c0, 16'h000A);
		wr(`PMS_REG_TMR_CMP, c1 + 16'h0004);
		repeat (100) @(posedge clk_sys);
		rdchk(`PMS_REG_IRQ_STAT, 16'h0002);
		wr(`PMS_REG_IRQ_STAT, 16'h000F);
		$display("test sleep timer done");
	endtask : t_timer

	task automatic t_ext();
		wr(`PMS_REG_IO_EN, 16'h0000);
		wr(`PMS_REG_CTRL, 16'h0083);
		wait_mode(`PMS_MODE_MIDDLE, 40, 9'h02F);
		@(posedge clk_sys);
		ext_rst_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		#1 chk({12'h000, cur_mode, pwr.regulator_on}, 16'h000F);
		@(posedge clk_sys);
		ext_rst_n <= 1'b1;
		n = 0;
		while (cpu_restart !== 1'b1 && n < 2200)
		begin
			@(posedge clk_sys);
			#1 n++;
		end
		chk({15'h0000, cpu_restart}, 16'h0001);
		rdchk(`PMS_REG_IRQ_STAT, 16'h0009);
		wr(`PMS_REG_IRQ_STAT, 16'h000F);
		$display("test external reset done");
	endtask : t_ext

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// Watchdog against a hung wait
	initial
	begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		test_done();
	end

	// Main sequence: reset, check of active mode straight after reset, then every scenario
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (8) @(posedge clk_sys);
		wait_mode(`PMS_MODE_ACTIVE, 3000, 9'h1A2);
		rdchk(`PMS_REG_IRQ_STAT, 16'h0000);
		wr(`PMS_REG_IRQ_STAT, 16'h000F);
		t_regs();
		t_idle_light();
		t_middle();
		t_deep();
		t_timer();
		t_ext();
		test_done();
	end
endmodule : power_mode_sequencer_bench
`default_nettype wire
